/* isml_cfg.svh */
`ifndef ISML_CFG_SVH
`define ISML_CFG_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ISML_OFS_MODE_CAL   12'h01F
`define ISML_OFS_MODE_A     12'h021
`define ISML_OFS_MODE_B     12'h022
`define ISML_OFS_STAT_ZERO  12'h023
`define ISML_OFS_STAT_A     12'h026
`define ISML_OFS_STAT_B     12'h027

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ISML_BIT_ROTATE_A   2
`define ISML_BIT_WINDOW_A   1
`define ISML_BIT_TRIP_A     0
`define ISML_BIT_POWER_B    7
`define ISML_BIT_BLANK_B    5
`define ISML_BIT_OSC_B      4
`define ISML_BIT_LOCKED_B   3
`define ISML_BIT_ROTATE_B   2
`define ISML_BIT_WINDOW_B   1
`define ISML_BIT_TRIP_B     0
`define ISML_BIT_CAL        7

// ----------------------------------------------------------------------
// masks and reset values
// ----------------------------------------------------------------------
`define ISML_MASK_MODE_B    8'hBF
`define ISML_RST_MODE_A     3'h0
`define ISML_RST_MODE_B     8'h00
`define ISML_RST_MODE_CAL   1'h0
`define ISML_RST_SRC        11'h000
`define ISML_RST_RDATA      8'h00
`define ISML_NUM_SRC        11

`endif

/* isml_pkg.sv */
package isml_pkg;

    // event inputs, packed so that bit i is source i
    typedef struct packed {
        logic cal_ok_flag;
        logic power_err_evt_b;
        logic blank_done_evt_b;
        logic osc_align_evt_b;
        logic locked_evt_b;
        logic rotate_evt_b;
        logic window_evt_b;
        logic trip_evt_b;
        logic rotate_evt_a;
        logic window_evt_a;
        logic trip_evt_a;
    } isml_evt_s;

    typedef struct packed {
        logic [11:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } isml_req_s;

    typedef struct packed {
        logic [2:0]  mode_a;
        logic [7:0]  mode_b;
        logic        mode_cal;
        logic [10:0] sync1;
        logic [10:0] sync2;
        logic [10:0] prev;
        logic [10:0] latched;
        logic        irq_n;
        logic [7:0]  rdata;
    } isml_state_s;

endpackage

/* isml_latch.sv */
`timescale 1ns/1ps
`include "isml_cfg.svh"
module isml_latch
    import isml_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire isml_evt_s   evt_in,
    input  wire isml_req_s   reg_req,
    output logic [7:0]       reg_rdata,
    output logic             irq_n
);

    // ------------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------------
    if (ADDR_W != 12) begin : g_bad_addr
        $error("isml_latch: ADDR_W must be 12");
    end

    // ------------------------------------------------------------------
    // state and per-source logic
    // ------------------------------------------------------------------
    isml_state_s st_reg;
    isml_state_s st_next;

    logic [10:0] mode_vec;
    logic [10:0] rise;
    logic [10:0] view;
    logic [10:0] clr;
    logic [10:0] latch_next;
    logic [10:0] mode_next_vec;
    logic [2:0]  mode_a_nx;
    logic [7:0]  mode_b_nx;
    logic        mode_cal_nx;

    // source order: a trip/window/rotate, b trip..blank, b power, cal
    assign mode_vec = {st_reg.mode_cal, st_reg.mode_b[`ISML_BIT_POWER_B],
                       st_reg.mode_b[5:0], st_reg.mode_a};
    // built from the write decode, not from st_next, so the comb path has no loop
    assign mode_next_vec = {mode_cal_nx, mode_b_nx[`ISML_BIT_POWER_B],
                            mode_b_nx[5:0], mode_a_nx};

    genvar gi;
    generate
        for (gi = 0; gi < `ISML_NUM_SRC; gi++) begin : g_src
            assign rise[gi] = st_reg.sync2[gi] & ~st_reg.prev[gi];
            // latched view only in latch mode, otherwise the live level
            assign view[gi] = mode_vec[gi] ? st_reg.latched[gi] : st_reg.sync2[gi];
            // set beats clear; latch parked at zero in live mode
            assign latch_next[gi] = mode_next_vec[gi] &
                                    ((st_reg.latched[gi] & ~clr[gi]) | rise[gi]);
        end
    endgenerate

    // ------------------------------------------------------------------
    // register write decode
    // ------------------------------------------------------------------
    logic wr_stat_a;
    logic wr_stat_b;
    logic wr_stat_z;

    assign wr_stat_a = reg_req.wr && (reg_req.addr == `ISML_OFS_STAT_A);
    assign wr_stat_b = reg_req.wr && (reg_req.addr == `ISML_OFS_STAT_B);
    assign wr_stat_z = reg_req.wr && (reg_req.addr == `ISML_OFS_STAT_ZERO);

    // write-one-to-clear, reserved bits dropped
    assign clr[2:0] = wr_stat_a ? reg_req.wdata[2:0] : 3'h0;
    assign clr[8:3] = wr_stat_b ? reg_req.wdata[5:0] : 6'h00;
    assign clr[9]   = wr_stat_b & reg_req.wdata[`ISML_BIT_POWER_B];
    assign clr[10]  = wr_stat_z & reg_req.wdata[`ISML_BIT_CAL];

    assign mode_a_nx = (reg_req.wr && reg_req.addr == `ISML_OFS_MODE_A) ?
                       reg_req.wdata[2:0] : st_reg.mode_a;
    assign mode_b_nx = (reg_req.wr && reg_req.addr == `ISML_OFS_MODE_B) ?
                       (reg_req.wdata & `ISML_MASK_MODE_B) : st_reg.mode_b;
    assign mode_cal_nx = (reg_req.wr && reg_req.addr == `ISML_OFS_MODE_CAL) ?
                         reg_req.wdata[`ISML_BIT_CAL] : st_reg.mode_cal;

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.mode_a   = mode_a_nx;
        st_next.mode_b   = mode_b_nx;
        st_next.mode_cal = mode_cal_nx;
        // events come from other domains, so two flops first
        st_next.sync1 = evt_in;
        st_next.sync2 = st_reg.sync1;
        st_next.prev  = st_reg.sync2;
        st_next.latched = latch_next;
        st_next.irq_n = ~|(latch_next & mode_next_vec);
        if (reg_req.rd) begin
            case (reg_req.addr)
                `ISML_OFS_MODE_A:    st_next.rdata = {5'h00, st_reg.mode_a};
                `ISML_OFS_MODE_B:    st_next.rdata = st_reg.mode_b;
                `ISML_OFS_MODE_CAL:  st_next.rdata = {st_reg.mode_cal, 7'h00};
                `ISML_OFS_STAT_A:    st_next.rdata = {5'h00, view[2:0]};
                `ISML_OFS_STAT_B:    st_next.rdata = {view[9], 1'b0, view[8:3]};
                `ISML_OFS_STAT_ZERO: st_next.rdata = {view[10], 7'h00};
                default:             st_next.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg.mode_a   <= `ISML_RST_MODE_A;
            st_reg.mode_b   <= `ISML_RST_MODE_B;
            st_reg.mode_cal <= `ISML_RST_MODE_CAL;
            st_reg.sync1    <= `ISML_RST_SRC;
            st_reg.sync2    <= `ISML_RST_SRC;
            st_reg.prev     <= `ISML_RST_SRC;
            st_reg.latched  <= `ISML_RST_SRC;
            st_reg.irq_n    <= 1'b1;
            st_reg.rdata    <= `ISML_RST_RDATA;
        end else begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata = st_reg.rdata;
    assign irq_n     = st_reg.irq_n;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    property p_rotate_a_latch;
        @(posedge clk) disable iff (sys_rst)
        (mode_vec[2] && !reg_req.wr && rise[2]) |=> (st_reg.latched[2] && !irq_n);
    endproperty
    a_rotate_a_latch: assert property (p_rotate_a_latch)
        else $error("rotate a did not latch");

    property p_window_a_live;
        @(posedge clk) disable iff (sys_rst)
        !mode_vec[1] |-> (view[1] == st_reg.sync2[1]) && !st_reg.latched[1];
    endproperty
    a_window_a_live: assert property (p_window_a_live)
        else $error("window a not live");

    property p_trip_a_irq;
        @(posedge clk) disable iff (sys_rst)
        (mode_vec[0] && rise[0] && !reg_req.wr) |=> !irq_n ##0 view[0];
    endproperty
    a_trip_a_irq: assert property (p_trip_a_irq)
        else $error("trip a no interrupt");

    property p_power_hold;
        @(posedge clk) disable iff (sys_rst)
        (st_reg.latched[9] && !clr[9] && !reg_req.wr) |=> st_reg.latched[9];
    endproperty
    a_power_hold: assert property (p_power_hold)
        else $error("power error latch lost");

    property p_blank_live;
        @(posedge clk) disable iff (sys_rst)
        !mode_vec[8] |-> view[8] == st_reg.sync2[8];
    endproperty
    a_blank_live: assert property (p_blank_live)
        else $error("blank done not live");

    property p_osc_irq;
        @(posedge clk) disable iff (sys_rst)
        (mode_vec[7] && rise[7] && !reg_req.wr) |=> !irq_n;
    endproperty
    a_osc_irq: assert property (p_osc_irq)
        else $error("osc align no interrupt");

    property p_evt_path;
        @(posedge clk) disable iff (sys_rst)
        (mode_vec[6] && !reg_req.wr && $rose(evt_in.locked_evt_b) && !st_reg.sync1[6]
         && !st_reg.sync2[6] && !st_reg.latched[6])
        ##1 (!reg_req.wr) ##1 (!reg_req.wr) |=> st_reg.latched[6];
    endproperty
    a_evt_path: assert property (p_evt_path)
        else $error("locked latch delay wrong");

    property p_clear_cal;
        @(posedge clk) disable iff (sys_rst)
        (st_reg.latched[10] && clr[10] && !rise[10]) |=> !st_reg.latched[10];
    endproperty
    a_clear_cal: assert property (p_clear_cal)
        else $error("cal latch not cleared");

    property p_cal_live;
        @(posedge clk) disable iff (sys_rst)
        !mode_vec[10] |-> view[10] == st_reg.sync2[10];
    endproperty
    a_cal_live: assert property (p_cal_live)
        else $error("cal status not live");

    property p_set_wins;
        @(posedge clk) disable iff (sys_rst)
        (mode_vec[10] && $stable(mode_vec) && rise[10] && clr[10]) |=> st_reg.latched[10];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("cal set lost to clear");

    property p_irq_level;
        @(posedge clk) disable iff (sys_rst)
        irq_n == !(|(st_reg.latched & mode_vec));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt level mismatch");

    property p_reserved;
        @(posedge clk) disable iff (sys_rst)
        !st_reg.mode_b[6] && !st_reg.rdata[6];
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved bit set");

    property p_rotate_b_latch;
        @(posedge clk) disable iff (sys_rst)
        (mode_vec[5] && rise[5] && !reg_req.wr) |=> (st_reg.latched[5] && !irq_n);
    endproperty
    a_rotate_b_latch: assert property (p_rotate_b_latch)
        else $error("rotate b did not latch");

    property p_window_b_read;
        @(posedge clk) disable iff (sys_rst)
        (reg_req.rd && reg_req.addr == `ISML_OFS_STAT_B && !mode_vec[4])
        |=> reg_rdata[1] == $past(st_reg.sync2[4]);
    endproperty
    a_window_b_read: assert property (p_window_b_read)
        else $error("window b read not live");

    property p_trip_b_read;
        @(posedge clk) disable iff (sys_rst)
        (reg_req.rd && reg_req.addr == `ISML_OFS_STAT_B && mode_vec[3] && st_reg.latched[3])
        |=> reg_rdata[0];
    endproperty
    a_trip_b_read: assert property (p_trip_b_read)
        else $error("trip b latch not read back");

    c_latch_irq: cover property (@(posedge clk) disable iff (sys_rst) $fell(irq_n));
    c_irq_release: cover property (@(posedge clk) disable iff (sys_rst) $rose(irq_n));
    c_cal_clear: cover property (@(posedge clk) disable iff (sys_rst)
        st_reg.latched[10] && clr[10]);
    c_set_clear: cover property (@(posedge clk) disable iff (sys_rst) rise[9] && clr[9]);

endmodule

/* isml_src_model.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// event source model
// ----------------------------------------------------------------------
module isml_src_model
    import isml_pkg::*;
(
    input  wire logic      clk,
    input  wire isml_evt_s want,
    output isml_evt_s      evt
);
    initial evt = '0;
    // levels move just after an edge, as an unrelated source would
    always @(posedge clk) begin
        evt <= want;
    end
endmodule

/* isml_latch_tb.sv */
`timescale 1ns/1ps
`include "isml_cfg.svh"
module isml_latch_tb
    import isml_pkg::*;
;
    logic        clk;
    logic        sys_rst;
    isml_evt_s   want;
    isml_evt_s   evt;
    isml_req_s   req;
    logic [7:0]  rdata;
    logic        irq_n;
    int          failures;
    int          checked;

    isml_latch #(.ADDR_W(12)) i_dut (
        .clk       (clk),
        .sys_rst   (sys_rst),
        .evt_in    (evt),
        .reg_req   (req),
        .reg_rdata (rdata),
        .irq_n     (irq_n)
    );

    isml_src_model i_src (.clk(clk), .want(want), .evt(evt));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    // ----------------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // released bus lines show inverted values, so stale data never matches
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk);
        req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk);
        req <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: 8'hA5};
        #1;
        chk(name, exp, rdata);
    endtask

    task automatic wait_irq(input logic lvl);
        int n;
        n = 0;
        while (irq_n !== lvl && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("irq_n", {7'h00, lvl}, {7'h00, irq_n});
        if (irq_n !== lvl) begin
            results();
        end
    endtask

    task results;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    function automatic logic [11:0] mode_ofs(input int i);
        return i < 3 ? `ISML_OFS_MODE_A : (i < 10 ? `ISML_OFS_MODE_B : `ISML_OFS_MODE_CAL);
    endfunction

    function automatic logic [11:0] stat_ofs(input int i);
        return i < 3 ? `ISML_OFS_STAT_A : (i < 10 ? `ISML_OFS_STAT_B : `ISML_OFS_STAT_ZERO);
    endfunction

    // bit 6 of pair B is reserved, so sources above it skip one place
    function automatic logic [7:0] msk(input int i);
        return i < 3 ? 8'h01 << i : (i < 9 ? 8'h01 << (i - 3) : 8'h80);
    endfunction

    // ----------------------------------------------------------------------
    // sequence
    // ----------------------------------------------------------------------
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        results();
    end

    initial begin
        req = '0;
        want = '0;
        sys_rst = 1'b1;
        failures = 0;
        checked = 0;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        rd(`ISML_OFS_MODE_A, 8'h00, "mode_a");
        rd(`ISML_OFS_MODE_B, 8'h00, "mode_b");
        rd(`ISML_OFS_STAT_ZERO, 8'h00, "stat_zero");
        chk("irq_n", 8'h01, {7'h00, irq_n});
        wr(`ISML_OFS_MODE_B, 8'hFF);
        rd(`ISML_OFS_MODE_B, 8'hBF, "mode_b");
        wr(`ISML_OFS_MODE_A, 8'hFF);
        rd(`ISML_OFS_MODE_A, 8'h07, "mode_a");
        wr(12'h3FF, 8'hFF);
        rd(12'h3FF, 8'h00, "unmapped");
        wr(`ISML_OFS_MODE_B, 8'h00);
        wr(`ISML_OFS_MODE_A, 8'h00);
        @(posedge clk);
        want <= 11'h7FF;
        repeat (5) @(posedge clk);
        rd(`ISML_OFS_STAT_A, 8'h07, "live_a");
        rd(`ISML_OFS_STAT_B, 8'hBF, "live_b");
        rd(`ISML_OFS_STAT_ZERO, 8'h80, "live_cal");
        chk("irq_n", 8'h01, {7'h00, irq_n});
        @(posedge clk);
        want <= '0;
        repeat (5) @(posedge clk);
        rd(`ISML_OFS_STAT_B, 8'h00, "live_b");
        rd(`ISML_OFS_STAT_ZERO, 8'h00, "live_cal");
        for (int i = 0; i < 11; i++) begin
            wr(mode_ofs(i), msk(i));
            @(posedge clk);
            want <= 11'h001 << i;
            wait_irq(1'b0);
            @(posedge clk);
            want <= '0;
            repeat (4) @(posedge clk);
            rd(stat_ofs(i), msk(i), "latched");
            wr(stat_ofs(i), msk(i));
            wait_irq(1'b1);
            rd(stat_ofs(i), 8'h00, "cleared");
            wr(mode_ofs(i), 8'h00);
        end
        wr(`ISML_OFS_MODE_A, 8'h01);
        wr(`ISML_OFS_MODE_B, 8'h01);
        @(posedge clk);
        want <= 11'h009;
        wait_irq(1'b0);
        @(posedge clk);
        want <= '0;
        wr(`ISML_OFS_STAT_A, 8'h01);
        repeat (4) @(posedge clk);
        #1;
        chk("irq_n", 8'h00, {7'h00, irq_n});
        wr(`ISML_OFS_STAT_B, 8'h01);
        wait_irq(1'b1);
        // a rise meeting a clear in the same cycle must stay latched
        wr(`ISML_OFS_MODE_B, 8'h80);
        @(posedge clk);
        want <= 11'h200;
        repeat (2) @(posedge clk);
        wr(`ISML_OFS_STAT_B, 8'h80);
        rd(`ISML_OFS_STAT_B, 8'h80, "set_wins");
        chk("irq_n", 8'h00, {7'h00, irq_n});
        // reset in mid-run drops modes, latches and the interrupt
        @(posedge clk);
        sys_rst <= 1'b1;
        @(posedge clk);
        #1;
        chk("rst_irq_n", 8'h01, {7'h00, irq_n});
        chk("rst_rdata", 8'h00, rdata);
        @(posedge clk);
        sys_rst <= 1'b0;
        rd(`ISML_OFS_MODE_B, 8'h00, "rst_mode_b");
        repeat (4) @(posedge clk);
        #1;
        chk("rst_irq_n", 8'h01, {7'h00, irq_n});
        results();
    end
endmodule
